//--- src/tcv_bist_ctrl.sv
// Trimming, XOR calibration and video self-test control register block
//
// Overview of operation
// - Writing one to trim enable launches trimming; hardware clears it at end.
// - Trimming end sets done flag bit 15 and result in pass bit 14.
// - Trim read request header byte is the 8-bit command field.
// - Writing one to XOR enable starts calibration; end clears it, sets bit 13.
// - Reading the register clears the XOR calibration done flag.
// - Byte select chooses test byte 8'h55 for zero, 8'hAA for one.
// - While XOR calibration runs, bits 3:0 set the minimum pulse width.
// - Video self-test emits red, green, blue, black, white frames repeatedly.
// - Run and enable bits start colour engine; after clearing run it stops at frame boundary.
//
// Local design decision: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "tcv_cfg.svh"

module tcv_bist_ctrl #(
  parameter logic [15:0] TRIM_TIMEOUT_CYC =
    16'(`TCV_TRIM_TIMEOUT_US * `TCV_CLK_MHZ),
  parameter logic [15:0] CAL_TIMEOUT_CYC  =
    16'(`TCV_CAL_TIMEOUT_US * `TCV_CLK_MHZ)
) (
  // Clock and reset
  input  wire logic                  clk_sys,
  input  wire logic                  rst_n,
  // Register port
  input  wire logic [7:0]            regAddr,
  input  wire logic [15:0]           regWdata,
  input  wire logic                  regWrite,
  input  wire logic                  regRead,
  output var  logic [15:0]           regRdata,
  // Trimming link
  output var  tcv_pkg::tcv_trim_req_t trimReq,
  input  wire logic                  trimReqReady,
  input  wire tcv_pkg::tcv_trim_rsp_t trimRsp,
  // XOR calibration
  input  wire logic                  calPulseIn,
  output var  logic [7:0]            calByte,
  output var  logic                  calActive,
  // Video self-test
  input  wire logic                  frameStart,
  output var  logic                  bistActive,
  output var  logic [23:0]           bistRgb,
  // Interrupt
  output var  logic                  irq
);

  // ==========================================================
  // Functions
  function automatic tcv_pkg::tcv_colour_t tcvNextColour(
    input tcv_pkg::tcv_colour_t c);
    case (c)
      tcv_pkg::COL_RED:   tcvNextColour = tcv_pkg::COL_GREEN;
      tcv_pkg::COL_GREEN: tcvNextColour = tcv_pkg::COL_BLUE;
      tcv_pkg::COL_BLUE:  tcvNextColour = tcv_pkg::COL_BLACK;
      tcv_pkg::COL_BLACK: tcvNextColour = tcv_pkg::COL_WHITE;
      default:            tcvNextColour = tcv_pkg::COL_RED;
    endcase
  endfunction : tcvNextColour

  function automatic logic [23:0] tcvRgb(input tcv_pkg::tcv_colour_t c);
    case (c)
      tcv_pkg::COL_RED:   tcvRgb = `TCV_RGB_RED;
      tcv_pkg::COL_GREEN: tcvRgb = `TCV_RGB_GREEN;
      tcv_pkg::COL_BLUE:  tcvRgb = `TCV_RGB_BLUE;
      tcv_pkg::COL_BLACK: tcvRgb = `TCV_RGB_BLACK;
      default:            tcvRgb = `TCV_RGB_WHITE;
    endcase
  endfunction : tcvRgb

  // ==========================================================
  // Register state
  logic                   trimDone;
  logic                   trimPass;
  logic                   xorDone;
  logic                   xorSel;
  logic                   xorEn;
  logic                   vidRun;
  logic                   vidEnable;
  logic [7:0]             cmdField;
  logic [2:0]             irqStat;
  logic [2:0]             irqMask;
  logic [2:0]             irqEvent;
  logic [2:0]             next_irqStat;

  // ==========================================================
  // Decode
  wire logic              selCtrl  = (regAddr == `TCV_ADDR_CTRL);
  wire logic              selStat  = (regAddr == `TCV_ADDR_IRQ_STAT);
  wire logic              selMask  = (regAddr == `TCV_ADDR_IRQ_MASK);
  wire logic              ctrlWr   = regWrite & selCtrl;
  wire logic              ctrlRd   = regRead & selCtrl;
  wire logic              statWr   = regWrite & selStat;
  wire logic              maskWr   = regWrite & selMask;
  wire logic              trimBusy;
  wire logic [15:0]       ctrlView;
  wire logic [15:0]       readMux;

  // ==========================================================
  // Trimming sequence
  tcv_pkg::tcv_trim_state_t trimState;
  tcv_pkg::tcv_trim_state_t next_trimState;
  logic [15:0]            trimCnt;
  logic [7:0]             trimHdr;

  wire logic trimStart  = ctrlWr & regWdata[`TCV_B_TRIM_EN] &
                          (trimState == tcv_pkg::TRIM_IDLE);
  wire logic trimTimeUp = (trimCnt == TRIM_TIMEOUT_CYC - 16'h0001);
  wire logic trimFinish = (trimState == tcv_pkg::TRIM_WAIT) &
                          (trimRsp.valid | trimTimeUp);
  wire logic trimOk     = trimRsp.valid & trimRsp.pass;
  assign trimBusy = (trimState != tcv_pkg::TRIM_IDLE);

  always_comb begin
    next_trimState = trimState;
    case (trimState)
      tcv_pkg::TRIM_IDLE: begin
        if (trimStart) begin
          next_trimState = tcv_pkg::TRIM_REQ;
        end
      end
      tcv_pkg::TRIM_REQ: begin
        if (trimReqReady) begin
          next_trimState = tcv_pkg::TRIM_WAIT;
        end
      end
      tcv_pkg::TRIM_WAIT: begin
        if (trimFinish) begin
          next_trimState = tcv_pkg::TRIM_IDLE;
        end
      end
      default: next_trimState = tcv_pkg::TRIM_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      trimState <= tcv_pkg::TRIM_IDLE;
    end else begin
      trimState <= next_trimState;
    end
  end

  // Counts only in TRIM_WAIT so a missing answer cannot hang the bit; no ready in TRIM_REQ still can
  always_ff @(posedge clk_sys) begin
    if (!rst_n || trimState != tcv_pkg::TRIM_WAIT) begin
      trimCnt <= 16'h0000;
    end else begin
      trimCnt <= trimCnt + 16'h0001;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      trimHdr  <= 8'h00;
      trimDone <= 1'b0;
      trimPass <= 1'b0;
    end else if (trimStart) begin
      trimHdr  <= regWdata[7:0];
      trimDone <= 1'b0;
      trimPass <= 1'b0;
    end else if (trimFinish) begin
      trimDone <= 1'b1;
      trimPass <= trimOk;
    end
  end

  assign trimReq.valid  = (trimState == tcv_pkg::TRIM_REQ);
  assign trimReq.header = trimHdr;

  // ==========================================================
  // XOR calibration
  logic                   calSync1;
  logic                   calSync2;
  logic                   calPrev;
  logic [4:0]             calWidth;
  logic [15:0]            calCnt;

  // Filter shares the low command nibble while calibration runs
  wire logic [3:0] calFilter = cmdField[3:0];
  wire logic calFall   = calPrev & ~calSync2;
  wire logic calQual   = calFall & (calWidth >= {1'b0, calFilter});
  wire logic calTimeUp = (calCnt == CAL_TIMEOUT_CYC - 16'h0001);
  wire logic xorStart  = ctrlWr & regWdata[`TCV_B_XOR_EN] & ~xorEn;
  wire logic xorFinish = xorEn & (calQual | calTimeUp);
  wire logic [4:0] calWidthInc =
    (calWidth == 5'h1F) ? calWidth : calWidth + 5'h01;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      calSync1 <= 1'b0;
      calSync2 <= 1'b0;
      calPrev  <= 1'b0;
      calWidth <= 5'h00;
    end else begin
      calSync1 <= calPulseIn;
      calSync2 <= calSync1;
      calPrev  <= calSync2;
      calWidth <= calSync2 ? calWidthInc : 5'h00;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n || !xorEn) begin
      calCnt <= 16'h0000;
    end else begin
      calCnt <= calCnt + 16'h0001;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      xorEn     <= 1'b0;
      xorDone   <= 1'b0;
      calByte   <= `TCV_BYTE_SEL0;
      calActive <= 1'b0;
    end else begin
      xorEn     <= xorStart | (xorEn & ~xorFinish);
      // A finish in the clearing read cycle still sets the flag
      xorDone   <= xorFinish | (xorDone & ~ctrlRd);
      calByte   <= xorSel ? `TCV_BYTE_SEL1 : `TCV_BYTE_SEL0;
      calActive <= xorEn;
    end
  end

  // ==========================================================
  // Video colour engine
  tcv_pkg::tcv_colour_t   vidColour;
  logic                   vidActive;

  wire logic vidGo = vidEnable & vidRun;
  wire logic vidStop = vidActive & frameStart & ~vidGo;
  wire tcv_pkg::tcv_colour_t vidNext =
    vidActive ? tcvNextColour(vidColour) : tcv_pkg::COL_RED;

  // Start and stop both wait for a boundary so no frame is cut short
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      vidActive <= 1'b0;
      vidColour <= tcv_pkg::COL_RED;
      bistRgb   <= 24'h000000;
    end else if (frameStart) begin
      vidActive <= vidGo;
      if (vidGo) begin
        vidColour <= vidNext;
        bistRgb   <= tcvRgb(vidNext);
      end else begin
        bistRgb   <= 24'h000000;
      end
    end
  end

  assign bistActive = vidActive;

  // ==========================================================
  // Control register writes
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      xorSel    <= 1'(`TCV_CTRL_RESET >> `TCV_B_XOR_SEL);
      vidRun    <= 1'(`TCV_CTRL_RESET >> `TCV_B_VID_RUN);
      vidEnable <= 1'(`TCV_CTRL_RESET >> `TCV_B_VID_EN);
      cmdField  <= 8'(`TCV_CTRL_RESET);
    end else if (ctrlWr) begin
      xorSel    <= regWdata[`TCV_B_XOR_SEL];
      vidRun    <= regWdata[`TCV_B_VID_RUN];
      vidEnable <= regWdata[`TCV_B_VID_EN];
      cmdField  <= regWdata[7:0];
    end
  end

  // ==========================================================
  // Interrupt status and mask
  assign irqEvent[`TCV_IRQ_TRIM] = trimFinish;
  assign irqEvent[`TCV_IRQ_XOR]  = xorFinish;
  assign irqEvent[`TCV_IRQ_VID]  = vidStop;

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : gIrq
      // Set wins over a write-one clear in the same cycle
      assign next_irqStat[gi] = irqEvent[gi] |
        (irqStat[gi] & ~(statWr & regWdata[gi]));
    end
  endgenerate

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      irqStat <= `TCV_IRQ_RESET;
      irqMask <= `TCV_IRQ_RESET;
      irq     <= 1'b0;
    end else begin
      irqStat <= next_irqStat;
      irq     <= |(next_irqStat & (maskWr ? regWdata[2:0] : irqMask));
      if (maskWr) begin
        irqMask <= regWdata[2:0];
      end
    end
  end

  // ==========================================================
  // Read path
  assign ctrlView = {trimDone, trimPass, xorDone, xorSel, xorEn,
                     vidRun, vidEnable, trimBusy, cmdField};
  assign readMux  = selCtrl ? ctrlView :
                    selStat ? {13'h0000, irqStat} :
                    selMask ? {13'h0000, irqMask} : 16'h0000;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      regRdata <= 16'h0000;
    end else begin
      regRdata <= regRead ? readMux : 16'h0000;
    end
  end

  // ==========================================================
  // Assertions
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  a_trim_start_clear: assert property (
    trimStart |=> !trimDone && !trimPass && trimBusy)
    else $error("trim start did not clear flags");
  a_trim_done_set: assert property (
    trimFinish |=> trimDone && !trimBusy && !ctrlView[`TCV_B_TRIM_EN])
    else $error("trim end did not set done or clear enable");
  a_trim_pass_value: assert property (
    trimFinish |=> trimPass == $past(trimRsp.valid && trimRsp.pass))
    else $error("trim pass flag wrong");
  a_trim_hdr_cmd: assert property (
    trimStart |=> trimReq.valid && trimReq.header == $past(regWdata[7:0]))
    else $error("trim header differs from command field");
  a_xor_done_set: assert property (
    xorFinish |=> xorDone && !xorEn)
    else $error("xor end did not set done");
  a_xor_read_clr: assert property (
    ctrlRd && !xorFinish |=> !xorDone)
    else $error("read did not clear xor done");
  a_xor_test_byte: assert property (
    xorEn ##1 xorEn |-> calByte ==
      ($past(xorSel) ? `TCV_BYTE_SEL1 : `TCV_BYTE_SEL0))
    else $error("xor test byte wrong");
  a_xor_short_pulse: assert property (
    xorEn && calFall && calWidth < {1'b0, cmdField[3:0]} && !calTimeUp
      |=> xorEn)
    else $error("short pulse ended calibration");
  a_vid_colour_seq: assert property (
    frameStart && vidActive && vidGo |=>
      vidColour == tcvNextColour($past(vidColour)) &&
      bistRgb == tcvRgb(vidColour))
    else $error("colour sequence wrong");
  a_vid_run_to_edge: assert property (
    vidActive && !frameStart |=> vidActive)
    else $error("engine stopped inside a frame");
  a_vid_stop_edge: assert property (
    frameStart && !vidGo |=> !vidActive ##1 !vidActive || frameStart)
    else $error("engine did not stop at boundary");

endmodule : tcv_bist_ctrl
`default_nettype wire

//--- src/tcv_cfg.svh
// Offsets, field positions, reset values and timing counts
`ifndef TCV_CFG_SVH
`define TCV_CFG_SVH
`define TCV_ADDR_CTRL       8'hEE
`define TCV_ADDR_IRQ_STAT   8'hF8
`define TCV_ADDR_IRQ_MASK   8'hF9
`define TCV_CTRL_RESET      16'h0000
`define TCV_IRQ_RESET       3'h0
`define TCV_B_TRIM_DONE     15
`define TCV_B_TRIM_PASS     14
`define TCV_B_XOR_DONE      13
`define TCV_B_XOR_SEL       12
`define TCV_B_XOR_EN        11
`define TCV_B_VID_RUN       10
`define TCV_B_VID_EN        9
`define TCV_B_TRIM_EN       8
`define TCV_IRQ_TRIM        0
`define TCV_IRQ_XOR         1
`define TCV_IRQ_VID         2
`define TCV_BYTE_SEL0       8'h55
`define TCV_BYTE_SEL1       8'hAA
`define TCV_RGB_RED         24'hFF0000
`define TCV_RGB_GREEN       24'h00FF00
`define TCV_RGB_BLUE        24'h0000FF
`define TCV_RGB_BLACK       24'h000000
`define TCV_RGB_WHITE       24'hFFFFFF
`define TCV_CLK_MHZ         50
`define TCV_TRIM_TIMEOUT_US 100
`define TCV_CAL_TIMEOUT_US  100
`endif

//--- src/tcv_pkg.sv
// Types shared by the trimming, calibration and video self-test control
`default_nettype none
package tcv_pkg;
  typedef enum logic [1:0] {
    TRIM_IDLE,
    TRIM_REQ,
    TRIM_WAIT
  } tcv_trim_state_t;

  typedef enum logic [2:0] {
    COL_RED,
    COL_GREEN,
    COL_BLUE,
    COL_BLACK,
    COL_WHITE
  } tcv_colour_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] header;
  } tcv_trim_req_t;

  typedef struct packed {
    logic valid;
    logic pass;
  } tcv_trim_rsp_t;
endpackage : tcv_pkg
`default_nettype wire

//--- dv/tcv_link_rx.sv
// Model of the far-end link receiver answering trimming read requests
`timescale 1ns/1ps
`default_nettype none

module tcv_link_rx (
  // Clock and reset
  input  wire logic                   clk_sys,
  input  wire logic                   rst_n,
  // Request and answer
  input  wire tcv_pkg::tcv_trim_req_t trimReq,
  output var  logic                   trimReqReady,
  output var  tcv_pkg::tcv_trim_rsp_t trimRsp,
  // Behaviour chosen by the bench
  input  wire logic [3:0]             readyLag,
  input  wire logic [3:0]             answerLag,
  input  wire logic                   answerPass,
  input  wire logic                   answerDrop,
  output var  logic [7:0]             seenHeader,
  output var  logic [3:0]             seenCount
);
  logic [3:0] waitCnt;
  logic       pending;

  // ==========================================================
  // Accept one request, answer after a programmable lag
  always_ff @(posedge clk_sys) begin
    // Pass toggles outside the answer pulse so misuse shows
    trimRsp <= '{valid: 1'b0, pass: ~trimRsp.pass};
    if (!rst_n) begin
      trimRsp      <= '{valid: 1'b0, pass: 1'b0};
      trimReqReady <= 1'b0;
      pending      <= 1'b0;
      waitCnt      <= 4'h0;
      seenHeader   <= 8'h00;
      seenCount    <= 4'h0;
    end else if (pending) begin
      waitCnt <= waitCnt + 4'h1;
      if (waitCnt == answerLag) begin
        pending <= 1'b0;
        // Dropped answer forces the device's own timeout
        trimRsp <= '{valid: !answerDrop, pass: answerPass};
      end
    end else if (trimReq.valid && trimReqReady) begin
      trimReqReady <= 1'b0;
      seenHeader   <= trimReq.header;
      seenCount    <= seenCount + 4'h1;
      pending      <= 1'b1;
      waitCnt      <= 4'h0;
    end else if (trimReq.valid) begin
      waitCnt      <= waitCnt + 4'h1;
      trimReqReady <= (waitCnt >= readyLag);
    end else begin
      waitCnt <= 4'h0;
    end
  end
endmodule : tcv_link_rx
`default_nettype wire

//--- dv/trim_calibration_video_bist_ctrl_tb.sv
// Self-checking bench for the trim, calibration and video self-test block
`timescale 1ns/1ps
`default_nettype none
`include "tcv_cfg.svh"

module trim_calibration_video_bist_ctrl_tb;
  logic                   clk_sys;
  logic                   rst_n;
  logic [7:0]             regAddr;
  logic [15:0]            regWdata;
  logic                   regWrite;
  logic                   regRead;
  logic [15:0]            regRdata;
  tcv_pkg::tcv_trim_req_t trimReq;
  logic                   trimReqReady;
  tcv_pkg::tcv_trim_rsp_t trimRsp;
  logic                   calPulseIn;
  logic [7:0]             calByte;
  logic                   calActive;
  logic                   frameStart;
  logic                   bistActive;
  logic [23:0]            bistRgb;
  logic                   irq;
  logic [3:0]             readyLag;
  logic [3:0]             answerLag;
  logic                   answerPass;
  logic                   answerDrop;
  logic [7:0]             seenHeader;
  integer                 seed;
  integer                 err_total;
  integer                 check_count;
  integer                 i;
  integer                 k;
  logic [15:0]            rd;
  logic [7:0]             cmd;

  // ==========================================================
  // Timeouts shortened so the refusal paths fit in the run
  tcv_bist_ctrl #(.TRIM_TIMEOUT_CYC(16'h003C), .CAL_TIMEOUT_CYC(16'h003C))
    dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .regAddr(regAddr),
    .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
    .regRdata(regRdata), .trimReq(trimReq), .trimReqReady(trimReqReady),
    .trimRsp(trimRsp), .calPulseIn(calPulseIn), .calByte(calByte),
    .calActive(calActive), .frameStart(frameStart),
    .bistActive(bistActive), .bistRgb(bistRgb), .irq(irq));

  tcv_link_rx link_u (.clk_sys(clk_sys), .rst_n(rst_n), .trimReq(trimReq),
    .trimReqReady(trimReqReady), .trimRsp(trimRsp), .readyLag(readyLag),
    .answerLag(answerLag), .answerPass(answerPass),
    .answerDrop(answerDrop), .seenHeader(seenHeader), .seenCount());

  // ==========================================================
  // Helpers
  function automatic logic [23:0] col(input integer n);
    case (n % 5)
      0: col = `TCV_RGB_RED;
      1: col = `TCV_RGB_GREEN;
      2: col = `TCV_RGB_BLUE;
      3: col = `TCV_RGB_BLACK;
      default: col = `TCV_RGB_WHITE;
    endcase
  endfunction : col

  task automatic chk(input string what, input logic [23:0] expv,
                     input logic [23:0] got);
    check_count = check_count + 1;
    if (got !== expv) begin
      err_total = err_total + 1;
      $display("BAD %s expected %h seen %h", what, expv, got);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    regAddr  <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge clk_sys);
    regWrite <= 1'b0;
  endtask : wr

  task automatic rdr(input logic [7:0] a);
    @(posedge clk_sys);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk_sys);
    regRead <= 1'b0;
    #1 rd = regRdata;
  endtask : rdr

  task automatic pulse(input integer n);
    @(posedge clk_sys);
    calPulseIn <= 1'b1;
    repeat (n) @(posedge clk_sys);
    calPulseIn <= 1'b0;
    repeat (10) @(posedge clk_sys);
  endtask : pulse

  task automatic frame;
    repeat (4) @(posedge clk_sys);
    frameStart <= 1'b1;
    @(posedge clk_sys);
    frameStart <= 1'b0;
    #1;
  endtask : frame

  task automatic trim_run(input logic p, input logic drop,
                          input logic [3:0] rl, input logic m);
    cmd = 8'($random(seed));
    readyLag   <= rl;
    answerLag  <= 4'($random(seed));
    answerPass <= p;
    answerDrop <= drop;
    wr(`TCV_ADDR_IRQ_MASK, {15'h0000, m});
    wr(`TCV_ADDR_CTRL, {8'h01, cmd});
    rdr(`TCV_ADDR_CTRL);
    chk("trim start view", {8'h01, cmd}, rd);
    for (i = 0; i < 200 && !rd[15]; i++) rdr(`TCV_ADDR_CTRL);
    chk("trim flags", {1'b1, p && !drop, 6'h00}, rd[15:8]);
    chk("trim header", cmd, seenHeader);
    chk("trim irq", m, irq);
    rdr(`TCV_ADDR_IRQ_STAT);
    chk("trim status", 1, rd[0]);
    wr(`TCV_ADDR_IRQ_STAT, 16'h0001);
    #1 chk("irq cleared", 0, irq);
  endtask : trim_run

  task automatic xor_run(input logic sel);
    wr(`TCV_ADDR_CTRL, {3'b000, sel, 1'b1, 7'h00, 4'h2});
    @(posedge clk_sys);
    #1 chk("cal byte", sel ? `TCV_BYTE_SEL1 : `TCV_BYTE_SEL0, calByte);
    chk("cal active", 1, calActive);
    pulse(1);
    rdr(`TCV_ADDR_CTRL);
    chk("short pulse kept running", 1, rd[11]);
    pulse(3);
    rdr(`TCV_ADDR_CTRL);
    chk("cal end view", {1'b1, sel, 1'b0}, rd[13:11]);
    chk("cal idle", 0, calActive);
    rdr(`TCV_ADDR_CTRL);
    chk("cal done after read", 0, rd[13]);
    rdr(`TCV_ADDR_IRQ_STAT);
    chk("cal status", 1, rd[1]);
    wr(`TCV_ADDR_IRQ_STAT, 16'h0002);
  endtask : xor_run

  task automatic end_of_test;
    $display("Checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : end_of_test

  // ==========================================================
  // Clock, watchdog and main sequence
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  initial begin
    repeat (20000) @(posedge clk_sys);
    err_total = err_total + 1;
    end_of_test();
  end

  initial begin
    seed = 97976;
    err_total = 0;
    check_count = 0;
    rst_n = 1'b0;
    {regAddr, regWdata, regWrite, regRead} = '0;
    {calPulseIn, frameStart, answerPass, answerDrop} = '0;
    readyLag = 4'h0;
    answerLag = 4'h0;
    repeat (12) @(posedge clk_sys);
    rst_n <= 1'b1;
    chk("reset cal byte", 8'h55, calByte);
    rdr(`TCV_ADDR_CTRL);
    chk("reset ctrl", `TCV_CTRL_RESET, rd);
    wr(`TCV_ADDR_CTRL, 16'hE000);
    rdr(`TCV_ADDR_CTRL);
    chk("read-only flags", 16'h0000, rd);
    wr(8'h10, 16'hFFFF);
    rdr(8'h10);
    chk("unmapped read", 16'h0000, rd);
    wr(`TCV_ADDR_IRQ_MASK, 16'h0007);
    rdr(`TCV_ADDR_IRQ_MASK);
    chk("mask readback", 16'h0007, rd);
    // Prompt, slow, masked and unanswered trimming runs
    for (k = 0; k < 4; k++) begin
      trim_run(1'($random(seed)), k == 3, k == 0 ? 4'h0 : 4'($random(seed)),
               k[0] == 1'b0);
    end
    wr(`TCV_ADDR_IRQ_MASK, 16'h0007);
    xor_run(1'b0);
    xor_run(1'b1);
    wr(`TCV_ADDR_CTRL, 16'h0600);
    for (k = 0; k < 7; k++) begin
      frame();
      chk("bist colour", col(k), bistRgb);
      chk("bist running", 1, bistActive);
    end
    wr(`TCV_ADDR_CTRL, 16'h0200);
    repeat (3) @(posedge clk_sys);
    chk("runs to boundary", col(6), bistRgb);
    frame();
    chk("bist stopped", 0, bistActive);
    chk("bist idle colour", 0, bistRgb);
    #1 chk("video irq", 1, irq);
    repeat (12) @(posedge clk_sys);
    wr(`TCV_ADDR_CTRL, 16'h0000);
    rdr(`TCV_ADDR_IRQ_STAT);
    chk("video status", 1, rd[2]);
    end_of_test();
  end
endmodule : trim_calibration_video_bist_ctrl_tb
`default_nettype wire
